// ===== src/seep_ctrl.sv
// Serial EEPROM command controller with a classic Wishbone register slave.
// Assumes one clock, a synchronous reset and an EEPROM on plain pins.
//
// Summary of operation
// - Writing one to bit 31 of the command register starts the coded operation at the cell index.
// - The pending bit stays set for the whole operation and clears only when it has finished.
// - When a read clears the pending bit, the fetched byte is already in the byte register.
// - A program cycle with no EEPROM attached keeps pending set until the timeout, then clears.
// - After reset the pending bit reads set while the station address loads automatically.
// - The pending bit clears once the automatic station-address load finishes or is abandoned.
// - The op code decodes as read, lock, unlock, write, fill all, erase, bulk erase, reload.
// - The pending bit and the op code field read zero after reset, apart from the auto load.
// - When a write, fill, erase or bulk erase gets no ready response within 30 ms the controller idles and sets the timeout flag.
// - The EEPROM cell is addressed by the 8-bit index in bits 7 to 0 of the command register.
// - The low byte of the byte register holds the byte read from or written to the EEPROM.
// - A reload fails, leaving the station id unloaded, unless cell zero holds 0xa5.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module seep_ctrl #(
    parameter int TIMEOUT_CYC = seep_pkg::TIMEOUT_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             ee_cs_o,
    output logic             ee_sk_o,
    output logic             ee_di_o,
    input  wire logic        ee_do_i,
    output logic      [47:0] station_id_o,
    output logic             station_id_loaded_o
);
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 16777215)
    begin : g_chk
        $error("seep_ctrl: TIMEOUT_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef enum logic [1:0] {C_IDLE, C_SHIFT, C_GAP, C_POLL} seep_ctl_e;
    typedef struct packed {
        seep_ctl_e                     st;
        logic                          pend;
        seep_pkg::seep_op_e            op;
        logic [7:0]                    addr;
        logic [7:0]                    data;
        logic                          to_flag;
        logic                          loaded;
        logic                          auto_ld;
        logic [2:0]                    step;
        logic [47:0]                   station;
        logic [23:0]                   cnt;
        logic [seep_pkg::IRQ_W-1:0]    stat;
        logic [seep_pkg::IRQ_W-1:0]    mask;
        logic                          ack;
        logic [31:0]                   rdat;
        logic                          irq;
        logic                          cs;
        logic                          sk;
        logic                          di;
        logic                          start;
        logic [seep_pkg::FRAME_W-1:0]  tx;
        logic [4:0]                    len;
    } seep_ctl_s;

    seep_ctl_s    q;
    seep_ctl_s    d;
    seep_shift_if sh();
    logic         do_s;
    logic         hit_w;
    logic         wr_w;
    logic         go_w;
    logic         rel_w;
    logic [5:0]   adr_w;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.
    seep_sync #(
        .W (1)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (ee_do_i),
        .q_o   (do_s)
    );

    seep_shift #(
        .HALF_CYC (seep_pkg::SK_HALF_CYC)
    ) u_shift (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sh    (sh)
    );

    assign sh.start   = q.start;
    assign sh.tx_bits = q.tx;
    assign sh.tx_len  = q.len;
    assign sh.miso    = do_s;

    // Builds {length, frame} for one operation; short frames still carry dt in the unused trailing bits.
    function automatic logic [23:0] frame(input seep_pkg::seep_op_e op,
                                          input logic [7:0] a,
                                          input logic [7:0] dt);
        logic [1:0] mw;
        logic [7:0] fa;
        logic [4:0] n;
        mw = seep_pkg::MW_EXT;
        fa = a;
        n  = seep_pkg::LEN_SHORT;
        case (op)
            seep_pkg::OP_READ:   begin mw = seep_pkg::MW_READ;  n = seep_pkg::LEN_LONG; end
            seep_pkg::OP_WRITE:  begin mw = seep_pkg::MW_WRITE; n = seep_pkg::LEN_LONG; end
            seep_pkg::OP_ERASE:  mw = seep_pkg::MW_ERASE;
            seep_pkg::OP_LOCK:   fa = seep_pkg::EXT_LOCK;
            seep_pkg::OP_UNLOCK: fa = seep_pkg::EXT_UNLOCK;
            seep_pkg::OP_FILL:   begin fa = seep_pkg::EXT_FILL; n = seep_pkg::LEN_LONG; end
            default:             fa = seep_pkg::EXT_BULK;
        endcase
        return {n, 1'b1, mw, fa, dt};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. Writes land at the edge where ack is seen high, as the master expects.
    assign hit_w = wb_cyc_i && wb_stb_i;
    assign wr_w  = hit_w && wb_we_i && q.ack;
    assign adr_w = wb_adr_i[7:2];
    assign go_w  = wr_w && (adr_w == seep_pkg::ADDR_CMD[7:2]) && !q.pend && wb_sel_i[3]
                   && wb_dat_i[seep_pkg::CMD_PEND_BIT];
    assign rel_w = q.auto_ld || (q.op == seep_pkg::OP_RELOAD);

    // Next-state logic for bus, registers and the command sequencer.
    always_comb
    begin
        logic [23:0]                fr;
        logic                       fin;
        logic [seep_pkg::IRQ_W-1:0] set;
        logic [seep_pkg::IRQ_W-1:0] clr;
        seep_pkg::seep_op_e         nop;
        logic [7:0]                 nadr;
        d     = q;
        fr    = 24'h0;
        fin   = 1'b0;
        set   = '0;
        clr   = '0;
        nop   = q.op;
        nadr  = q.addr;
        d.start = 1'b0;
        d.ack   = hit_w && !q.ack;

        // Read mux; unmapped words read zero and are still acknowledged.
        d.rdat = 32'h0;
        if (adr_w == seep_pkg::ADDR_CMD[7:2])
            d.rdat = {q.pend, q.op, 18'h0, q.to_flag, q.loaded, q.addr};
        else if (adr_w == seep_pkg::ADDR_DATA[7:2])
            d.rdat = {24'h0, q.data};
        else if (adr_w == seep_pkg::ADDR_STAT[7:2])
            d.rdat = {29'h0, q.stat};
        else if (adr_w == seep_pkg::ADDR_MASK[7:2])
            d.rdat = {29'h0, q.mask};

        // Register writes. Command and byte register are frozen while busy.
        if (wr_w && adr_w == seep_pkg::ADDR_CMD[7:2] && !q.pend)
        begin
            if (wb_sel_i[3])
                nop = seep_pkg::seep_op_e'(wb_dat_i[30:28]);
            if (wb_sel_i[0])
                nadr = wb_dat_i[7:0];
            d.op   = nop;
            d.addr = nadr;
        end
        if (wr_w && adr_w == seep_pkg::ADDR_DATA[7:2] && !q.pend && wb_sel_i[0])
            d.data = wb_dat_i[7:0];
        if (wr_w && adr_w == seep_pkg::ADDR_STAT[7:2] && wb_sel_i[0])
            clr = wb_dat_i[seep_pkg::IRQ_W-1:0];
        if (wr_w && adr_w == seep_pkg::ADDR_MASK[7:2] && wb_sel_i[0])
            d.mask = wb_dat_i[seep_pkg::IRQ_W-1:0];

        // Sequencer. A reload reads the signature cell, then the six station bytes.
        case (q.st)
            C_IDLE:
            if (q.auto_ld || go_w)
            begin
                d.pend    = 1'b1;
                d.to_flag = 1'b0;
                d.step    = 3'h0;
                d.st      = C_SHIFT;
                d.start   = 1'b1;
                if (q.auto_ld || nop == seep_pkg::OP_RELOAD)
                begin
                    d.loaded = 1'b0;
                    fr = frame(seep_pkg::OP_READ, 8'h00, 8'h00);
                end
                else
                    fr = frame(nop, nadr, (nop == seep_pkg::OP_READ) ? 8'h00 : q.data);
            end
            C_SHIFT:
            if (sh.done)
            begin
                if (rel_w && q.step == 3'h0 && sh.rx_byte != seep_pkg::RELOAD_SIG)
                begin
                    fin = 1'b1;
                    set[seep_pkg::IRQ_LDFAIL] = 1'b1;
                end
                else if (rel_w)
                begin
                    if (q.step != 3'h0)
                        d.station = {sh.rx_byte, q.station[47:8]};
                    if (q.step == 3'(seep_pkg::STATION_BYTES))
                    begin
                        d.loaded = 1'b1;
                        fin      = 1'b1;
                    end
                    else
                    begin
                        d.step  = 3'(q.step + 3'h1);
                        d.start = 1'b1;
                        fr = frame(seep_pkg::OP_READ, {5'h0, d.step}, 8'h00);
                    end
                end
                else if (q.op == seep_pkg::OP_READ)
                begin
                    d.data = sh.rx_byte;
                    fin    = 1'b1;
                end
                else if (q.op == seep_pkg::OP_WRITE || q.op == seep_pkg::OP_FILL ||
                         q.op == seep_pkg::OP_ERASE || q.op == seep_pkg::OP_BULK)
                begin
                    d.st  = C_GAP;
                    d.cnt = 24'h0;
                end
                else
                    fin = 1'b1;
            end
            C_GAP:
            begin
                // Chip select low between frame and ready poll lets the EEPROM start.
                d.cnt = 24'(q.cnt + 24'h1);
                if (q.cnt == 24'(seep_pkg::GAP_CYC - 1))
                begin
                    d.st  = C_POLL;
                    d.cnt = 24'h0;
                end
            end
            C_POLL:
            begin
                // A missing part leaves the line low, so only the timeout ends the wait.
                d.cnt = 24'(q.cnt + 24'h1);
                if (do_s)
                    fin = 1'b1;
                else if (q.cnt == 24'(TIMEOUT_CYC - 1))
                begin
                    d.to_flag = 1'b1;
                    set[seep_pkg::IRQ_TO] = 1'b1;
                    fin = 1'b1;
                end
            end
            default: d.st = C_IDLE;
        endcase

        if (d.start)
            {d.len, d.tx} = fr;
        if (fin)
        begin
            d.pend    = 1'b0;
            d.auto_ld = 1'b0;
            d.st      = C_IDLE;
            set[seep_pkg::IRQ_DONE] = 1'b1;
        end

        // Sticky events: a new event beats a clear in the same cycle.
        d.stat = (q.stat & ~clr) | set;
        d.irq  = |(d.stat & d.mask);
        d.cs   = sh.cs || (q.st == C_POLL);
        d.sk   = sh.sk;
        d.di   = sh.di;
    end

    // State register; reset starts the automatic station load with the op field zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q         <= '0;
            q.pend    <= 1'b1;
            q.auto_ld <= 1'b1;
            q.data    <= seep_pkg::DATA_RST;
            q.mask    <= seep_pkg::MASK_RST;
        end
        else
            q <= d;
    end

    assign wb_dat_o            = q.rdat;
    assign wb_ack_o            = q.ack;
    assign irq_o               = q.irq;
    assign ee_cs_o             = q.cs;
    assign ee_sk_o             = q.sk;
    assign ee_di_o             = q.di;
    assign station_id_o        = q.station;
    assign station_id_loaded_o = q.loaded;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_start;
        go_w && q.st == C_IDLE && !q.auto_ld |=> q.pend && q.st == C_SHIFT && q.start;
    endproperty
    a_start: assert property (p_start) else $error("start write did not launch");

    property p_busy;
        q.st != C_IDLE |-> q.pend;
    endproperty
    a_busy: assert property (p_busy) else $error("pending clear while active");

    property p_rdata;
        $fell(q.pend) && q.op == seep_pkg::OP_READ && !$past(q.auto_ld) |-> q.data == sh.rx_byte;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read byte not valid at completion");

    property p_tmo;
        q.st == C_POLL && !do_s && q.cnt == 24'(TIMEOUT_CYC - 1) |=> q.to_flag && !q.pend;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout not flagged");

    property p_rst;
        $fell(rst_i) |-> q.pend && q.auto_ld && q.op == seep_pkg::OP_READ;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");

    property p_end;
        $fell(q.pend) |-> q.st == C_IDLE && !q.auto_ld && q.stat[seep_pkg::IRQ_DONE];
    endproperty
    a_end: assert property (p_end) else $error("pending fell outside completion");

    property p_dec;
        q.start && q.op == seep_pkg::OP_READ && !q.auto_ld |-> q.tx[18:16] == 3'h6 && q.len == 5'd19;
    endproperty
    a_dec: assert property (p_dec) else $error("read frame malformed");

    property p_addr;
        q.start && q.op == seep_pkg::OP_ERASE |-> q.tx[15:8] == q.addr && q.tx[17:16] == 2'h3;
    endproperty
    a_addr: assert property (p_addr) else $error("erase frame address wrong");

    property p_wdata;
        q.start && q.op == seep_pkg::OP_WRITE |-> q.tx[7:0] == q.data;
    endproperty
    a_wdata: assert property (p_wdata) else $error("write frame data wrong");

    property p_sig;
        q.st == C_SHIFT && sh.done && rel_w && q.step == 3'h0 && sh.rx_byte != 8'ha5
        |=> !q.loaded && !q.pend ##1 !q.loaded;
    endproperty
    a_sig: assert property (p_sig) else $error("unprogrammed part accepted");
endmodule

// ===== src/seep_pkg.sv
// Constants shared by the serial EEPROM command controller and its helpers.
// Assumes a single 50 MHz clock and a three-wire serial EEPROM with byte cells.
package seep_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the register bus.
    localparam logic [7:0] ADDR_CMD  = 8'hb0;
    localparam logic [7:0] ADDR_DATA = 8'hb4;
    localparam logic [7:0] ADDR_STAT = 8'hb8;
    localparam logic [7:0] ADDR_MASK = 8'hbc;

    // Field positions inside the command register.
    localparam int CMD_PEND_BIT   = 31;
    localparam int CMD_OP_LSB     = 28;
    localparam int CMD_TO_BIT     = 9;
    localparam int CMD_LOADED_BIT = 8;

    // Event bits of the status and mask registers.
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_TO     = 1;
    localparam int IRQ_LDFAIL = 2;
    localparam int IRQ_W      = 3;

    // Reset values of the software fields.
    localparam logic [7:0]       DATA_RST = 8'h00;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

    // Station address load.
    localparam logic [7:0] RELOAD_SIG    = 8'ha5;
    localparam int         STATION_BYTES = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Timing, derived from the clock period.
    localparam int CLK_PERIOD_NS = 20;
    localparam int TIMEOUT_MS    = 30;
    localparam int TIMEOUT_CYC   = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SK_HALF_NS    = 500;
    localparam int SK_HALF_CYC   = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC       = 2 * SK_HALF_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame layout: start bit, two opcode bits, address, data.
    localparam int         FRAME_W    = 19;
    localparam logic [4:0] LEN_SHORT  = 5'd11;
    localparam logic [4:0] LEN_LONG   = 5'd19;
    localparam logic [1:0] MW_EXT     = 2'b00;
    localparam logic [1:0] MW_WRITE   = 2'b01;
    localparam logic [1:0] MW_READ    = 2'b10;
    localparam logic [1:0] MW_ERASE   = 2'b11;
    localparam logic [7:0] EXT_LOCK   = 8'h00;
    localparam logic [7:0] EXT_FILL   = 8'h40;
    localparam logic [7:0] EXT_BULK   = 8'h80;
    localparam logic [7:0] EXT_UNLOCK = 8'hc0;

    // Operation codes in the order of their field encoding.
    typedef enum logic [2:0] {
        OP_READ, OP_LOCK, OP_UNLOCK, OP_WRITE, OP_FILL, OP_ERASE, OP_BULK, OP_RELOAD
    } seep_op_e;

endpackage

// ===== src/seep_shift.sv
// Serial shift engine: clocks one framed command out, samples the return line.
// Assumes the return line is already synchronised and frames are MSB aligned.
`timescale 1ns/1ps
module seep_shift #(
    parameter int HALF_CYC = seep_pkg::SK_HALF_CYC
) (
    input wire logic   clk_i,
    input wire logic   rst_i,
    seep_shift_if.eng  sh
);
    if (HALF_CYC < 1 || HALF_CYC > 65535)
    begin : g_chk
        $error("seep_shift: HALF_CYC out of range");
    end

    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} seep_sh_e;
    typedef struct packed {
        seep_sh_e                     st;
        logic [15:0]                  div;
        logic [4:0]                   left;
        logic [seep_pkg::FRAME_W-1:0] sreg;
        logic [7:0]                   rx;
        logic                         sk;
        logic                         cs;
        logic                         di;
        logic                         done;
    } seep_sh_s;

    seep_sh_s q;
    seep_sh_s d;
    logic     half_w;

    assign half_w = (q.div == 16'(HALF_CYC - 1));

    // Each bit is a low half then a high half; data changes while the clock is low.
    // Bits past the frame shift out as zero, so reads simply extend the length.
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        d.div  = half_w ? 16'h0 : 16'(q.div + 16'h1);
        case (q.st)
            SH_IDLE:
            begin
                d.div = 16'h0;
                if (sh.start)
                begin
                    d.st   = SH_LOW;
                    d.cs   = 1'b1;
                    d.sreg = sh.tx_bits;
                    d.di   = sh.tx_bits[seep_pkg::FRAME_W-1];
                    d.left = sh.tx_len;
                end
            end
            SH_LOW:
            if (half_w)
            begin
                d.st = SH_HIGH;
                d.sk = 1'b1;
            end
            SH_HIGH:
            if (half_w)
            begin
                d.sk   = 1'b0;
                d.rx   = {q.rx[6:0], sh.miso};
                d.sreg = {q.sreg[seep_pkg::FRAME_W-2:0], 1'b0};
                d.di   = q.sreg[seep_pkg::FRAME_W-2];
                d.left = 5'(q.left - 5'h1);
                d.st   = SH_LOW;
                if (q.left == 5'h1)
                begin
                    d.st   = SH_IDLE;
                    d.cs   = 1'b0;
                    d.di   = 1'b0;
                    d.done = 1'b1;
                end
            end
            default: d.st = SH_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign sh.done    = q.done;
    assign sh.rx_byte = q.rx;
    assign sh.sk      = q.sk;
    assign sh.cs      = q.cs;
    assign sh.di      = q.di;
endmodule

// ===== src/seep_shift_if.sv
// Interface between the command controller and the serial shift engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface seep_shift_if;
    logic                       start;
    logic [seep_pkg::FRAME_W-1:0] tx_bits;
    logic [4:0]                 tx_len;
    logic                       miso;
    logic                       done;
    logic [7:0]                 rx_byte;
    logic                       sk;
    logic                       cs;
    logic                       di;

    modport ctrl (output start, tx_bits, tx_len, miso, input done, rx_byte, sk, cs, di);
    modport eng  (input start, tx_bits, tx_len, miso, output done, rx_byte, sk, cs, di);
endinterface

// ===== src/seep_sync.sv
// Two-flop synchroniser for levels arriving from pins.
// Assumes the destination clock is clk_i; the first stage feeds only the second.
`timescale 1ns/1ps
module seep_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } seep_sync_s;

    seep_sync_s q;
    seep_sync_s d;

    // Shift the pin level through both stages.
    always_comb
    begin
        d    = q;
        d.s1 = d_i;
        d.s2 = q.s1;
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign q_o = q.s2;
endmodule

// ===== test/seep_ctrl_tb.sv
// Self-checking bench for the command controller with a model EEPROM.
// Assumes the timeout is shortened to 200 cycles.
`timescale 1ns/1ps
module seep_ctrl_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        absent = 1'b0;
    logic        ack, irq, cs, sk, di, dout, loaded, first;
    logic [7:0]  adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat, d;
    logic [47:0] sid;
    int          mismatches = 0;
    int          compares = 0;
    int          polls;
    always #10 clk_i = ~clk_i;
    seep_ctrl #(.TIMEOUT_CYC(200)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .ee_cs_o(cs), .ee_sk_o(sk),
        .ee_di_o(di), .ee_do_i(dout), .station_id_o(sid), .station_id_loaded_o(loaded));
    seep_eeprom_model u_ee (.cs_i(cs), .sk_i(sk), .di_i(di), .absent_i(absent), .do_o(dout));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; ack and read data are taken at the rising edge where ack is high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= v;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_i);
        end
        d = rdat;
        chk(48'(n < 20), 48'h1);
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    // Polls the pending bit; the bound stops a stuck controller from hanging.
    task automatic wait_idle();
        polls = 0;
        bus(1'b0, seep_pkg::ADDR_CMD, 32'h0);
        first = d[31];
        while (d[31] !== 1'b0 && polls < 5000)
        begin
            polls++;
            bus(1'b0, seep_pkg::ADDR_CMD, 32'h0);
        end
    endtask
    task automatic run_op(input seep_pkg::seep_op_e op, input logic [7:0] idx);
        bus(1'b1, seep_pkg::ADDR_CMD, {1'b1, op, 20'h0, idx});
        wait_idle();
        chk(48'(first), 48'h1);
        chk(48'(d[31]), 48'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, seep_pkg::ADDR_CMD, 32'h0);
        chk(48'(d[31:28]), 48'h8);
        wait_idle();
        chk(48'(d[8]), 48'h1);
        chk(sid, 48'h060504030201);
    endtask
    task automatic t_irq();
        bus(1'b1, seep_pkg::ADDR_MASK, 32'h7);
        repeat (2) @(negedge clk_i);
        chk(48'(irq), 48'h1);
        bus(1'b1, seep_pkg::ADDR_STAT, 32'h7);
        repeat (2) @(negedge clk_i);
        chk(48'(irq), 48'h0);
        @(posedge clk_i);
    endtask
    task automatic t_ops();
        run_op(seep_pkg::OP_UNLOCK, 8'h00);
        bus(1'b1, seep_pkg::ADDR_DATA, 32'h5c);
        run_op(seep_pkg::OP_WRITE, 8'h20);
        run_op(seep_pkg::OP_READ, 8'h20);
        bus(1'b0, seep_pkg::ADDR_DATA, 32'h0);
        chk(48'(d[7:0]), 48'h5c);
        run_op(seep_pkg::OP_ERASE, 8'h20);
        run_op(seep_pkg::OP_READ, 8'h37);
        bus(1'b0, seep_pkg::ADDR_DATA, 32'h0);
        chk(48'(d[7:0]), 48'h37);
        run_op(seep_pkg::OP_READ, 8'h20);
        bus(1'b0, seep_pkg::ADDR_DATA, 32'h0);
        chk(48'(d[7:0]), 48'hff);
        run_op(seep_pkg::OP_LOCK, 8'h00);
        run_op(seep_pkg::OP_FILL, 8'h00);
        run_op(seep_pkg::OP_BULK, 8'h00);
        chk(48'(d[9]), 48'h0);
    endtask
    // Frame, gap and a 200 cycle poll take about 800 cycles, three cycles per status read.
    task automatic t_timeout();
        absent <= 1'b1;
        run_op(seep_pkg::OP_ERASE, 8'h01);
        chk(48'(d[9]), 48'h1);
        chk(48'(polls > 240), 48'h1);
        bus(1'b0, seep_pkg::ADDR_STAT, 32'h0);
        chk(48'(d[1]), 48'h1);
        absent <= 1'b0;
    endtask
    task automatic t_reload_fail();
        bus(1'b1, seep_pkg::ADDR_DATA, 32'h0);
        run_op(seep_pkg::OP_WRITE, 8'h00);
        run_op(seep_pkg::OP_RELOAD, 8'h00);
        chk(48'(d[8]), 48'h0);
        chk(48'(loaded), 48'h0);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_irq();
        t_ops();
        t_timeout();
        t_reload_fail();
        give_verdict();
    end
    // Whole run is near 17000 cycles; this cuts a hang well past that.
    initial
    begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
endmodule

// ===== test/seep_eeprom_model.sv
// Behavioural serial EEPROM: 256 byte cells, read, write and erase.
// Assumes frames of start bit, two op bits, index, then data, MSB first.
`timescale 1ns/1ps
module seep_eeprom_model (
    input  wire logic cs_i,
    input  wire logic sk_i,
    input  wire logic di_i,
    input  wire logic absent_i,
    output logic      do_o
);
    logic [7:0]  mem [256];
    logic [18:0] sr = '0;
    logic [1:0]  op = '0;
    logic [7:0]  adr = '0;
    logic        drv = 1'b1;
    int          cnt = 0;
    // A missing part leaves the line pulled low, so program cycles never end.
    assign do_o = absent_i ? 1'b0 : drv;
    // Cell zero holds the signature, cells one to six the station id.
    initial
    begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i);
        mem[0] = 8'ha5;
    end
    // Shift on the rising serial clock; a read answers its byte MSB first.
    always @(posedge sk_i)
    begin
        sr = {sr[17:0], di_i};
        cnt++;
        if (cnt == 11) {op, adr} = sr[9:0];
        drv = (op == seep_pkg::MW_READ && cnt > 11 && cnt < 20) ? mem[adr][19-cnt] : 1'b1;
    end
    // A frame ends when select falls; programming lands then.
    always @(negedge cs_i)
    begin
        if (cnt == 19 && op == seep_pkg::MW_WRITE) mem[adr] = sr[7:0];
        if (cnt == 11 && op == seep_pkg::MW_ERASE) mem[adr] = 8'hff;
        cnt = 0;
    end
endmodule
